// ---- hdl/cspi_ctrl.sv ----
// Purpose: Socket power control and interrupt/general control register pair
// Assumes: Host register window gives one-cycle byte read and write strobes
// Notes:   Power register layout follows the register model field
//
// Summary of operation
// - Output enable bit drives card_output_enable one cycle later and gates no other output; cleared at reset.
// - Alternate layout bits 6,5 and 2 always read zero.
// - Supply field 00/01 is 0 V, 10 is 5 V, 11 is 3.3 V.
// - Program field 00 none, 01 supply, 10 is 12 V, 11 reserved.
// - Program request ignored unless socket supply is on.
// - Ring enable switches shared battery input to ring indicate.
// - Card reset bit 0 asserts card reset, 1 releases it.
// - Card kind bit: 0 memory card, 1 I/O card.
// - Route bit sends status-change interrupts to host lines, else select field.
// - Select code 0000 routes nothing and forces host routing of status change.
// - Nonzero select routes card interrupt of an I/O card only; 0010 is management interrupt.
// - Register model field chooses which power register layout applies.
`timescale 1ns/1ps
module cspi_ctrl (
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire cspi_pkg::cspi_req_t  req,
  input  wire logic [3:0]           register_model_field,
  input  wire logic [3:0]           status_change_irq_select,
  input  wire logic                 card_irq,
  input  wire logic                 card_status_change,
  input  wire logic                 battery_detect_ring_input,
  output logic [7:0]                rdata,
  output logic                      card_output_enable,
  output logic [1:0]                supply_voltage_request,
  output logic [1:0]                program_voltage_request,
  output logic                      card_reset,
  output logic                      installed_card_kind,
  output logic                      ring_indicate,
  output logic                      battery_detect,
  output logic [15:0]               irq_lines,
  output logic                      system_management_interrupt,
  output logic                      status_change_to_host,
  output logic [3:0]                status_change_select_out
);
  import cspi_pkg::*;

  logic [7:0]  power_q, power_d;
  logic [7:0]  igc_q, igc_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        alt_layout;
  cspi_power_t pwr_d, pwr_q;
  logic        crst_q, crst_d, kind_q, kind_d, ri_q, ri_d, bd_q, bd_d;
  logic [15:0] irq_q, irq_d;
  logic        mgmt_q, mgmt_d, csch_q, csch_d;
  logic [3:0]  cssel_q, cssel_d;

  // Mask for writable bits in the active layout
  function automatic logic [7:0] power_mask(input logic alt);
    power_mask = alt ? CSPI_POWER_ALT_MASK : CSPI_POWER_STD_MASK;
  endfunction : power_mask

  // Any model code other than the standard one picks the alternate layout
  assign alt_layout = (register_model_field != CSPI_MODEL_STD);

  // Register writes; reserved positions never take state
  always_comb begin
    power_d = power_q & power_mask(alt_layout);
    igc_d   = igc_q;
    if (req.wr && req.addr == CSPI_OFS_POWER) begin
      power_d = req.wdata & power_mask(alt_layout);
    end
    if (req.wr && req.addr == CSPI_OFS_IRQ_GEN) begin
      igc_d = req.wdata;
    end
  end

  // Read data; reserved bits read zero because they are masked
  always_comb begin
    rdata_d = rdata_q;
    if (req.rd) begin
      unique case (req.addr)
        CSPI_OFS_POWER:  rdata_d = power_q & power_mask(alt_layout);
        CSPI_OFS_IRQ_GEN: rdata_d = igc_q;
        default:         rdata_d = 8'h00;
      endcase
    end
  end

  // Socket power decode; the program rail only follows while supply is on
  always_comb begin
    logic vcc_on;
    vcc_on = 1'b0;
    pwr_d.card_output_enable = power_q[CSPI_OE_BIT];
    if (alt_layout) begin
      unique case (cspi_vcc_t'(power_q[CSPI_ALT_VCC_LSB +: 2]))
        CSPI_VCC_5V:  pwr_d.supply_voltage_request = CSPI_VCC_5V;
        CSPI_VCC_3V3: pwr_d.supply_voltage_request = CSPI_VCC_3V3;
        CSPI_VCC_OFF, CSPI_VCC_OFF2: pwr_d.supply_voltage_request = CSPI_VCC_OFF;
      endcase
    end else begin
      // Standard layout only has an on bit; treat it as a 5 V request
      pwr_d.supply_voltage_request = power_q[CSPI_STD_VCC_BIT] ? CSPI_VCC_5V : CSPI_VCC_OFF;
    end
    vcc_on = (pwr_d.supply_voltage_request != CSPI_VCC_OFF);
    // Reserved code 11 is dropped rather than passed to the switch
    if (vcc_on && power_q[CSPI_VPP_LSB +: 2] != CSPI_VPP_RSVD) begin
      pwr_d.program_voltage_request = power_q[CSPI_VPP_LSB +: 2];
    end else begin
      pwr_d.program_voltage_request = CSPI_VPP_NC;
    end
  end

  // Card control and interrupt routing
  always_comb begin
    logic [3:0] sel;
    sel      = igc_q[CSPI_SEL_LSB +: 4];
    crst_d   = ~igc_q[CSPI_CRST_BIT];
    kind_d   = igc_q[CSPI_KIND_BIT];
    // Shared input goes to one function only, so the other sees idle
    ri_d     = igc_q[CSPI_RING_BIT] & battery_detect_ring_input;
    bd_d     = ~igc_q[CSPI_RING_BIT] & battery_detect_ring_input;
    irq_d    = 16'h0000;
    mgmt_d   = 1'b0;
    // Interrupts only mean something for an I/O card
    if (kind_d && sel == CSPI_IRQ_MGMT) begin
      mgmt_d = card_irq;
    end else if (kind_d && sel != CSPI_IRQ_NONE) begin
      irq_d[sel] = card_irq;
    end
    csch_d   = card_status_change & (igc_q[CSPI_ROUTE_BIT] | (sel == CSPI_IRQ_NONE));
    cssel_d  = (igc_q[CSPI_ROUTE_BIT] | (sel == CSPI_IRQ_NONE)) ? 4'h0 : status_change_irq_select;
  end

  // State registers
  always_ff @(posedge clock) begin
    if (rst) begin
      power_q <= CSPI_RESET_VALUE;
      igc_q   <= CSPI_RESET_VALUE;
      rdata_q <= 8'h00;
      pwr_q   <= '0;
      crst_q  <= 1'b1;
      kind_q  <= 1'b0;
      ri_q    <= 1'b0;
      bd_q    <= 1'b0;
      irq_q   <= 16'h0000;
      mgmt_q  <= 1'b0;
      csch_q  <= 1'b0;
      cssel_q <= 4'h0;
    end else begin
      power_q <= power_d;
      igc_q   <= igc_d;
      rdata_q <= rdata_d;
      pwr_q   <= pwr_d;
      crst_q  <= crst_d;
      kind_q  <= kind_d;
      ri_q    <= ri_d;
      bd_q    <= bd_d;
      irq_q   <= irq_d;
      mgmt_q  <= mgmt_d;
      csch_q  <= csch_d;
      cssel_q <= cssel_d;
    end
  end

  assign rdata                       = rdata_q;
  assign card_output_enable          = pwr_q.card_output_enable;
  assign supply_voltage_request      = pwr_q.supply_voltage_request;
  assign program_voltage_request     = pwr_q.program_voltage_request;
  assign card_reset                  = crst_q;
  assign installed_card_kind         = kind_q;
  assign ring_indicate               = ri_q;
  assign battery_detect              = bd_q;
  assign irq_lines                   = irq_q;
  assign system_management_interrupt = mgmt_q;
  assign status_change_to_host       = csch_q;
  assign status_change_select_out    = cssel_q;

  // Output enable follows the bit one stage after the register
  property p_oe;
    @(posedge clock) disable iff (rst) 1 |=> card_output_enable == $past(power_q[CSPI_OE_BIT]);
  endproperty
  a_oe: assert property (p_oe) else $error("output enable mismatch");

  property p_alt_rsvd;
    @(posedge clock) disable iff (rst) (req.rd && req.addr == CSPI_OFS_POWER && alt_layout) |=> rdata[6:5] == 2'b00 && !rdata[2];
  endproperty
  a_alt_rsvd: assert property (p_alt_rsvd) else $error("reserved power bits not zero");

  property p_vcc;
    @(posedge clock) disable iff (rst) (alt_layout && power_q[4:3] == 2'b01) |=> supply_voltage_request == 2'b00;
  endproperty
  a_vcc: assert property (p_vcc) else $error("supply code 01 not off");

  property p_vpp_rsvd;
    @(posedge clock) disable iff (rst) 1 |-> program_voltage_request != 2'b11;
  endproperty
  a_vpp_rsvd: assert property (p_vpp_rsvd) else $error("reserved program code driven");

  property p_vpp_off;
    @(posedge clock) disable iff (rst) supply_voltage_request == 2'b00 |-> program_voltage_request == 2'b00;
  endproperty
  a_vpp_off: assert property (p_vpp_off) else $error("program rail with supply off");

  property p_ring;
    @(posedge clock) disable iff (rst) !igc_q[CSPI_RING_BIT] |=> !ring_indicate;
  endproperty
  a_ring: assert property (p_ring) else $error("ring indicate while disabled");

  sequence s_wr_reset(logic v);
    req.wr && req.addr == CSPI_OFS_IRQ_GEN && req.wdata[CSPI_CRST_BIT] == v;
  endsequence
  property p_crst;
    @(posedge clock) disable iff (rst) s_wr_reset(1'b0) |=> ##1 card_reset;
  endproperty
  a_crst: assert property (p_crst) else $error("card reset not asserted");

  property p_route;
    @(posedge clock) disable iff (rst) (igc_q[CSPI_ROUTE_BIT] && card_status_change) |=> status_change_to_host;
  endproperty
  a_route: assert property (p_route) else $error("status change not routed to host");

  property p_none;
    @(posedge clock) disable iff (rst) igc_q[3:0] == 4'h0 |=> irq_lines == 16'h0000 && !system_management_interrupt;
  endproperty
  a_none: assert property (p_none) else $error("interrupt routed with select zero");

  property p_mgmt;
    @(posedge clock) disable iff (rst)
      (igc_q[3:0] == 4'h2 && igc_q[5] && card_irq) |=> system_management_interrupt && irq_lines == 16'h0000;
  endproperty
  a_mgmt: assert property (p_mgmt) else $error("management interrupt not selected");

  property p_kind;
    @(posedge clock) disable iff (rst) 1 |=> installed_card_kind == $past(igc_q[CSPI_KIND_BIT]);
  endproperty
  a_kind: assert property (p_kind) else $error("card kind mismatch");

  // Program request passes through once the supply is on
  property p_vpp_pass;
    @(posedge clock) disable iff (rst) (alt_layout && power_q[4] && power_q[1:0] != 2'b11) |=> program_voltage_request == $past(power_q[1:0]);
  endproperty
  a_vpp_pass: assert property (p_vpp_pass) else $error("program request not passed");

  // Supply code 10 requests 5 V
  property p_vcc_5v;
    @(posedge clock) disable iff (rst) (alt_layout && power_q[4:3] == 2'b10) |=> supply_voltage_request == 2'b10;
  endproperty
  a_vcc_5v: assert property (p_vcc_5v) else $error("supply code 10 not 5 V");

  // Supply code 11 requests 3.3 V
  property p_vcc_3v3;
    @(posedge clock) disable iff (rst) (alt_layout && power_q[4:3] == 2'b11) |=> supply_voltage_request == 2'b11;
  endproperty
  a_vcc_3v3: assert property (p_vcc_3v3) else $error("supply code 11 not 3.3 V");

  // Standard layout on bit still powers the socket
  property p_std_vcc;
    @(posedge clock) disable iff (rst) (!alt_layout && power_q[CSPI_STD_VCC_BIT]) |=> supply_voltage_request == 2'b10;
  endproperty
  a_std_vcc: assert property (p_std_vcc) else $error("standard layout supply off");

  // Standard layout reserved bits read zero
  property p_std_rsvd;
    @(posedge clock) disable iff (rst) (req.rd && req.addr == CSPI_OFS_POWER && !alt_layout) |=> !rdata[6] && rdata[3:2] == 2'b00;
  endproperty
  a_std_rsvd: assert property (p_std_rsvd) else $error("standard reserved bits not zero");

  // Control register reads back what it holds
  property p_igc_read;
    @(posedge clock) disable iff (rst) (req.rd && req.addr == CSPI_OFS_IRQ_GEN) |=> rdata == $past(igc_q);
  endproperty
  a_igc_read: assert property (p_igc_read) else $error("control read back mismatch");

  // Unmapped offsets read as zero
  property p_unmapped;
    @(posedge clock) disable iff (rst) (req.rd && req.addr != CSPI_OFS_POWER && req.addr != CSPI_OFS_IRQ_GEN) |=> rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  // Ring mode hides the battery function of the shared input
  property p_bd;
    @(posedge clock) disable iff (rst) igc_q[CSPI_RING_BIT] |=> !battery_detect;
  endproperty
  a_bd: assert property (p_bd) else $error("battery detect while ring enabled");

  // Writing the reset bit high releases the card two edges later
  property p_crst_rel;
    @(posedge clock) disable iff (rst) s_wr_reset(1'b1) |=> ##1 !card_reset;
  endproperty
  a_crst_rel: assert property (p_crst_rel) else $error("card reset not released");

  // Numbered codes drive exactly the matching line
  property p_irq_line;
    @(posedge clock) disable iff (rst) (igc_q[5] && igc_q[3:0] != 4'h0 && igc_q[3:0] != 4'h2 && card_irq) |=> irq_lines == (16'h0001 << $past(igc_q[3:0]));
  endproperty
  a_irq_line: assert property (p_irq_line) else $error("wrong interrupt line");

  // A memory card never raises a functional interrupt
  property p_mem_quiet;
    @(posedge clock) disable iff (rst) !igc_q[CSPI_KIND_BIT] |=> irq_lines == 16'h0000 && !system_management_interrupt;
  endproperty
  a_mem_quiet: assert property (p_mem_quiet) else $error("interrupt from memory card");

  // Without host routing the external select field steers status change
  property p_sel_out;
    @(posedge clock) disable iff (rst) (!igc_q[4] && igc_q[3:0] != 4'h0) |=> status_change_select_out == $past(status_change_irq_select);
  endproperty
  a_sel_out: assert property (p_sel_out) else $error("status change select not passed");

  // Select code zero forces host routing of status change
  property p_host_sel;
    @(posedge clock) disable iff (rst) (igc_q[3:0] == 4'h0 && card_status_change) |=> status_change_to_host && status_change_select_out == 4'h0;
  endproperty
  a_host_sel: assert property (p_host_sel) else $error("select zero did not route to host");
endmodule : cspi_ctrl

// ---- hdl/cspi_pkg.sv ----
// Purpose: Constants and types for the socket power and interrupt control bank
// Assumes: Byte-wide registers at socket register window offsets
// Notes:   Register model field selects the power register layout
package cspi_pkg;
  localparam logic [7:0] CSPI_OFS_POWER      = 8'h02;
  localparam logic [7:0] CSPI_OFS_IRQ_GEN    = 8'h03;
  localparam logic [7:0] CSPI_RESET_VALUE    = 8'h00;
  localparam logic [7:0] CSPI_POWER_ALT_MASK = 8'h9b;
  localparam logic [7:0] CSPI_POWER_STD_MASK = 8'hb3;
  localparam int         CSPI_OE_BIT         = 7;
  localparam int         CSPI_AUTOSW_BIT     = 5;
  localparam int         CSPI_STD_VCC_BIT    = 4;
  localparam int         CSPI_ALT_VCC_LSB    = 3;
  localparam int         CSPI_VPP_LSB        = 0;
  localparam int         CSPI_RING_BIT       = 7;
  localparam int         CSPI_CRST_BIT       = 6;
  localparam int         CSPI_KIND_BIT       = 5;
  localparam int         CSPI_ROUTE_BIT      = 4;
  localparam int         CSPI_SEL_LSB        = 0;
  localparam logic [3:0] CSPI_MODEL_STD      = 4'h2;
  localparam logic [3:0] CSPI_IRQ_NONE       = 4'h0;
  localparam logic [3:0] CSPI_IRQ_MGMT       = 4'h2;

  typedef enum logic [1:0] {
    CSPI_VCC_OFF  = 2'b00,
    CSPI_VCC_OFF2 = 2'b01,
    CSPI_VCC_5V   = 2'b10,
    CSPI_VCC_3V3  = 2'b11
  } cspi_vcc_t;

  typedef enum logic [1:0] {
    CSPI_VPP_NC   = 2'b00,
    CSPI_VPP_VCC  = 2'b01,
    CSPI_VPP_12V  = 2'b10,
    CSPI_VPP_RSVD = 2'b11
  } cspi_vpp_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cspi_req_t;

  typedef struct packed {
    logic       card_output_enable;
    logic [1:0] supply_voltage_request;
    logic [1:0] program_voltage_request;
  } cspi_power_t;
endpackage : cspi_pkg

// ---- verif/cspi_card_model.sv ----
// Purpose: Behavioural card sitting in the socket
// Assumes: Bench asks for interrupt, status-change and battery levels
// Notes:   A card held in reset keeps its functional interrupt quiet
`timescale 1ns/1ps
module cspi_card_model (
  input  wire logic card_reset,
  input  wire logic irq_want,
  input  wire logic chg_want,
  input  wire logic bvd_want,
  output logic      card_irq,
  output logic      card_status_change,
  output logic      battery_detect_ring_input
);
  // Card pins follow the requested levels; reset silences the interrupt
  assign card_irq                  = irq_want & ~card_reset;
  assign card_status_change        = chg_want;
  assign battery_detect_ring_input = bvd_want;
endmodule : cspi_card_model

// ---- verif/card_socket_power_irq_control_test.sv ----
// Purpose: Self-checking bench for the socket power and interrupt bank
// Assumes: Outputs settle two cycles after a write, read data one after
// Notes:   No random stimulus; every expectation is computed here
`timescale 1ns/1ps
module card_socket_power_irq_control_test;
  import cspi_pkg::*;
  logic clock, rst, irq_want, chg_want, bvd_want, oe, crst, kind, ring, batt, mgmt, to_host;
  logic cirq, cchg, cbvd;
  cspi_req_t req;
  logic [3:0] model_field, csc_sel, sel_out;
  logic [7:0] rdata;
  logic [1:0] vcc, vpp;
  logic [15:0] irq_lines;
  int bad_count, tests_run;

  cspi_ctrl i_cspi_ctrl (.clock(clock), .rst(rst), .req(req), .register_model_field(model_field),
    .status_change_irq_select(csc_sel), .card_irq(cirq), .card_status_change(cchg),
    .battery_detect_ring_input(cbvd), .rdata(rdata), .card_output_enable(oe),
    .supply_voltage_request(vcc), .program_voltage_request(vpp), .card_reset(crst),
    .installed_card_kind(kind), .ring_indicate(ring), .battery_detect(batt), .irq_lines(irq_lines),
    .system_management_interrupt(mgmt), .status_change_to_host(to_host), .status_change_select_out(sel_out));
  cspi_card_model i_cspi_card_model (.card_reset(crst), .irq_want(irq_want), .chg_want(chg_want),
    .bvd_want(bvd_want), .card_irq(cirq), .card_status_change(cchg), .battery_detect_ring_input(cbvd));

  // Free-running 25 MHz clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Strobe held for exactly one taken edge, then wait for outputs to follow
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    req <= '0;
    repeat (2) @(posedge clock);
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock);
    req <= '0;
    @(posedge clock);
    #1;
    chk("read data", rdata, exp);
  endtask : rd

  task automatic t_reset;
    chk("card reset", crst, 1'b1);
    chk("output enable", oe, 1'b0);
    chk("card kind", kind, 1'b0);
    rd(8'h02, 8'h00);
    rd(8'h03, 8'h00);
    rd(8'h05, 8'h00);
    $display("test reset done");
  endtask : t_reset

  // Every supply and program code pair in the alternate layout
  task automatic t_power;
    logic [1:0] ev, ep;
    model_field <= 4'h0;
    wr(8'h02, 8'hff);
    rd(8'h02, 8'h9b);
    chk("output enable", oe, 1'b1);
    chk("reserved program", vpp, 2'b00);
    for (int i = 0; i < 16; i++) begin
      wr(8'h02, {3'b000, i[3:2], 1'b0, i[1:0]});
      ev = (i[3:2] == 2'b01) ? 2'b00 : i[3:2];
      ep = (ev != 2'b00 && i[1:0] != 2'b11) ? i[1:0] : 2'b00;
      chk("supply", vcc, ev);
      chk("program", vpp, ep);
      chk("output enable", oe, 1'b0);
    end
    model_field <= CSPI_MODEL_STD;
    wr(8'h02, 8'hff);
    rd(8'h02, 8'hb3);
    $display("test power done");
  endtask : t_power

  task automatic t_general;
    bvd_want <= 1'b1;
    wr(8'h03, 8'hff);
    rd(8'h03, 8'hff);
    chk("card reset", crst, 1'b0);
    chk("card kind", kind, 1'b1);
    chk("ring", {ring, batt}, 2'b10);
    wr(8'h03, 8'h40);
    chk("ring", {ring, batt}, 2'b01);
    $display("test general done");
  endtask : t_general

  // Walk all functional interrupt codes with an I/O card
  task automatic t_route;
    irq_want <= 1'b1;
    chg_want <= 1'b1;
    csc_sel  <= 4'h5;
    for (int s = 0; s < 16; s++) begin
      wr(8'h03, 8'h60 | 8'(s));
      chk("irq lines", irq_lines, (s != 0 && s != 2) ? 16'h0001 << s : 16'h0000);
      chk("management irq", mgmt, s == 2);
      chk("host route", to_host, s == 0);
      chk("select out", sel_out, (s == 0) ? 4'h0 : 4'h5);
    end
    wr(8'h03, 8'h73);
    chk("host route", {to_host, sel_out}, 5'h10);
    wr(8'h03, 8'h43);
    chk("irq lines", irq_lines, 16'h0000);
    $display("test route done");
  endtask : t_route

  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim

  // Hang guard well beyond the roughly 180 cycles needed
  initial begin
    repeat (5000) @(posedge clock);
    bad_count++;
    end_sim();
  end

  initial begin
    rst = 1'b1;
    req = '0;
    model_field = 4'h0;
    csc_sel = 4'h0;
    {irq_want, chg_want, bvd_want} = 3'b000;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1;
    t_reset();
    t_power();
    t_general();
    t_route();
    end_sim();
  end
endmodule : card_socket_power_irq_control_test
